//--- rx_fifo_pkg.sv
// Package of modes, widths and thresholds for the receive core FIFO
package rx_fifo_pkg;
    localparam int DATA_W        = 64;
    localparam int CTRL_W        = 2;
    localparam int THRESH_W      = 6;
    localparam int DEPTH_DEF     = 16;
    localparam logic [THRESH_W-1:0] PFULL_DEF  = 6'h05;
    localparam logic [THRESH_W-1:0] PEMPTY_DEF = 6'h02;
    // Word kinds carried on the control lane
    localparam logic [CTRL_W-1:0] KIND_DATA = 2'h0;
    localparam logic [CTRL_W-1:0] KIND_CTRL = 2'h1;
    localparam logic [CTRL_W-1:0] KIND_SYNC = 2'h2;
    localparam logic [CTRL_W-1:0] KIND_OS   = 2'h3;
    // Idle word inserted for rate compensation
    localparam logic [DATA_W-1:0] IDLE_WORD = 64'h0707070707070707;
    // Slack kept when rate compensation inserts or deletes
    localparam int RC_LOW_MARK   = 4;
    localparam int RC_HIGH_MARK  = 12;
    typedef enum logic [2:0] {
        MODE_REG_BASIC = 3'b001,
        MODE_ILKN      = 3'b010,
        MODE_TENG      = 3'b100
    } fifo_mode_e;
    typedef enum logic [2:0] {
        CTL_IDLE  = 3'b001,
        CTL_RUN   = 3'b010,
        CTL_HOLD  = 3'b100
    } ctl_state_e;
endpackage

//--- rx_fifo_if.sv
// Interface joining the FIFO device end to the fabric end
`timescale 1ns/1ps
interface rx_fifo_if;
    import rx_fifo_pkg::*;
    logic [DATA_W-1:0] readData;
    logic [CTRL_W-1:0] readKind;
    logic              readValid;
    logic              readEnable;
    logic              writeEnable;
    logic              fifoFull;
    logic              fifoEmpty;
    logic              fifoPartFull;
    logic              fifoPartEmpty;
    modport device (output readData, readKind, readValid, fifoFull, fifoEmpty, fifoPartFull, fifoPartEmpty,
                    input readEnable, writeEnable);
    modport fabric (input readData, readKind, readValid, fifoFull, fifoEmpty, fifoPartFull, fifoPartEmpty,
                    output readEnable, writeEnable);
endinterface

//--- elastic_fifo.sv
// Parameterised storage FIFO with valid and ready on both sides
`timescale 1ns/1ps
module elastic_fifo #(
    parameter int WIDTH = 66,
    parameter int DEPTH = 16
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic [WIDTH-1:0]         inData,
    input  wire logic                     inValid,
    output logic                          inReady,
    output logic [WIDTH-1:0]              outData,
    output logic                          outValid,
    input  wire logic                     outReady,
    output logic [$clog2(DEPTH+1)-1:0]    level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW-1:0]    next_wrPtr;
    logic [AW-1:0]    next_rdPtr;
    logic [$clog2(DEPTH+1)-1:0] next_level;
    logic             push;
    logic             pop;

    // Handshakes; full and empty straight from the level
    always_comb begin
        inReady    = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
        outValid   = (level != '0);
        push       = inValid && inReady;
        pop        = outValid && outReady;
        next_wrPtr = push ? AW'(wrPtr + 1'b1) : wrPtr;
        next_rdPtr = pop ? AW'(rdPtr + 1'b1) : rdPtr;
        next_level = level;
        if (push && !pop) begin
            next_level = level + 1'b1;
        end else if (pop && !push) begin
            next_level = level - 1'b1;
        end
        outData    = mem[rdPtr];
    end

    // Pointer and level registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            level <= next_level;
        end
    end

    // Storage has no reset, so it can map to RAM
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule

//--- rx_core_fifo.sv
// Device end: receive core FIFO with basic, deskew and rate compensation modes
// Functional notes
// - Register-basic: input register then elastic FIFO
// - Register-basic only for 32/40-bit widths; here DATA_W is 64
// - Basic mode is a clock-crossing elastic buffer; here one ref_clk drives both sides
// - Fabric controls enables to avoid over/underflow
// - Fabric state machine performs Interlaken lane deskew; here it only waits for the laneAligned input
// - 10GBASE-R forwards data only after block lock
// - 10GBASE-R deletes ordered sets, inserts idles
// - Fabric ignores status flags outside Interlaken/basic
// - Partially-full threshold 0..63, default 5
// - Partially-empty threshold 0..63, default 2
// - Sync-word removal after frame lock, first included
// - Control-word removal after frame lock
// - Write and read sides are separate domains; here both sides run on ref_clk
// - Partially-full flag at threshold occupancy
// - Empty flag registered on read clock
`timescale 1ns/1ps
module rx_core_fifo
    import rx_fifo_pkg::*;
#(
    parameter int DEPTH = rx_fifo_pkg::DEPTH_DEF
) (
    input  wire logic                               ref_clk,
    input  wire logic                               rst,
    input  wire rx_fifo_pkg::fifo_mode_e            fifoMode,
    input  wire logic [rx_fifo_pkg::THRESH_W-1:0]   partFullThresh,
    input  wire logic [rx_fifo_pkg::THRESH_W-1:0]   partEmptyThresh,
    input  wire logic                               syncDropEn,
    input  wire logic                               ctrlDropEn,
    input  wire logic                               blockLock,
    input  wire logic                               frameLock,
    input  wire logic [rx_fifo_pkg::DATA_W-1:0]     rxData,
    input  wire logic [rx_fifo_pkg::CTRL_W-1:0]     rxKind,
    output logic                                    wordDeleted,
    rx_fifo_if.device                               link
);
    import rx_fifo_pkg::*;
    // One level bit more than the pointers, so full and empty differ
    localparam int LW = $clog2(DEPTH+1);

    // Input register stage: the PCS-side FIFO reduced to a register
    logic [DATA_W-1:0] inReg;
    logic [CTRL_W-1:0] kindReg;
    logic              inRegValid;
    logic              bLockMeta;
    logic              bLockSync;
    logic              fLockMeta;
    logic              fLockSync;
    logic [DATA_W-1:0] next_inReg;
    logic [CTRL_W-1:0] next_kindReg;
    logic              next_inRegValid;
    logic              next_wordDeleted;

    // FIFO side signals
    logic [DATA_W+CTRL_W-1:0] fInData;
    logic                     fInValid;
    logic                     fInReady;
    logic [DATA_W+CTRL_W-1:0] fOutData;
    logic                     fOutValid;
    logic                     fOutReady;
    logic [LW-1:0]            level;

    // Output side registers
    logic [DATA_W-1:0] next_readData;
    logic [CTRL_W-1:0] next_readKind;
    logic              next_readValid;
    logic              next_full;
    logic              next_empty;
    logic              next_pfull;
    logic              next_pempty;
    logic              dropWord;
    logic              insertIdle;
    logic              takeWord;

    // Lock status comes from the PCS, so synchronise it first
    // The first stages feed nothing but the second, to contain metastability
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bLockMeta <= 1'b0;
            bLockSync <= 1'b0;
            fLockMeta <= 1'b0;
            fLockSync <= 1'b0;
        end else begin
            bLockMeta <= blockLock;
            bLockSync <= bLockMeta;
            fLockMeta <= frameLock;
            fLockSync <= fLockMeta;
        end
    end

    // Write-side filtering: word drop decisions before storage
    // Dropped words never reach storage, so they cost no space
    always_comb begin
        dropWord = 1'b0;
        unique case (fifoMode)
            MODE_ILKN: begin
                if (fLockSync && syncDropEn && kindReg == KIND_SYNC) begin
                    dropWord = 1'b1;
                end
                if (fLockSync && ctrlDropEn && kindReg == KIND_CTRL) begin
                    dropWord = 1'b1;
                end
            end
            MODE_TENG: begin
                // Deleting only at or above the high mark keeps slack for bursts
                if (!bLockSync) begin
                    dropWord = 1'b1;
                end else if (kindReg == KIND_OS && level >= LW'(RC_HIGH_MARK)) begin
                    dropWord = 1'b1;
                end
            end
            // Register-basic drops no word here; only the fabric write enable and a full FIFO stop storage
            default: dropWord = 1'b0;
        endcase
        fInData  = {kindReg, inReg};
        // Basic and Interlaken obey the fabric write enable; 10G writes freely
        fInValid = inRegValid && !dropWord && (fifoMode == MODE_TENG || link.writeEnable);
        // Register stage always loads; a stalled word is lost, as in hardware
        next_inReg       = rxData;
        next_kindReg     = rxKind;
        next_inRegValid  = 1'b1;
        next_wordDeleted = inRegValid && fifoMode == MODE_TENG && bLockSync && kindReg == KIND_OS
                           && level >= LW'(RC_HIGH_MARK);
    end

    // Input register stage
    // Kind resets to plain data so no false drop follows reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inReg       <= '0;
            kindReg     <= KIND_DATA;
            inRegValid  <= 1'b0;
            wordDeleted <= 1'b0;
        end else begin
            inReg       <= next_inReg;
            kindReg     <= next_kindReg;
            inRegValid  <= next_inRegValid;
            wordDeleted <= next_wordDeleted;
        end
    end

    // Shared clock here; a two-clock build would swap this for gray pointers
    // Each entry carries the kind lane beside the data word
    elastic_fifo #(
        .WIDTH (DATA_W + CTRL_W),
        .DEPTH (DEPTH)
    ) u_store (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inData   (fInData),
        .inValid  (fInValid),
        .inReady  (fInReady),
        .outData  (fOutData),
        .outValid (fOutValid),
        .outReady (fOutReady),
        .level    (level)
    );

    // Read side: pop on enable outside 10G; 10G pops freely but inserts idles instead when it runs low
    always_comb begin
        takeWord   = 1'b0;
        insertIdle = 1'b0;
        if (fifoMode == MODE_TENG) begin
            // Idles only once locked; before lock the output stays silent
            if (bLockSync && level <= LW'(RC_LOW_MARK)) begin
                insertIdle = 1'b1;
            end else begin
                takeWord = fOutValid;
            end
        end else begin
            // Basic and Interlaken read strictly on the fabric's request
            takeWord = link.readEnable && fOutValid;
        end
        fOutReady      = takeWord;
        next_readData  = insertIdle ? IDLE_WORD : fOutData[DATA_W-1:0];
        next_readKind  = insertIdle ? KIND_OS : fOutData[DATA_W+CTRL_W-1:DATA_W];
        next_readValid = takeWord || insertIdle;
        next_full      = !fInReady;
        next_empty     = (level == '0);
        // Compared as integers: a partially-full threshold past the depth is simply never reached
        next_pfull     = (int'(level) >= int'(partFullThresh));
        next_pempty    = (int'(level) <= int'(partEmptyThresh));
    end

    // Output registers toward fabric
    // Flags lag the level by a cycle, so the fabric keeps margin
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link.readData      <= '0;
            link.readKind      <= KIND_DATA;
            link.readValid     <= 1'b0;
            link.fifoFull      <= 1'b0;
            link.fifoEmpty     <= 1'b1;
            link.fifoPartFull  <= 1'b0;
            link.fifoPartEmpty <= 1'b1;
        end else begin
            link.readData      <= next_readData;
            link.readKind      <= next_readKind;
            link.readValid     <= next_readValid;
            link.fifoFull      <= next_full;
            link.fifoEmpty     <= next_empty;
            link.fifoPartFull  <= next_pfull;
            link.fifoPartEmpty <= next_pempty;
        end
    end
endmodule

//--- rx_fabric_ctl.sv
// Fabric end: state machine managing the FIFO enables from its flags
`timescale 1ns/1ps
module rx_fabric_ctl
    import rx_fifo_pkg::*;
(
    input  wire logic                               ref_clk,
    input  wire logic                               rst,
    input  wire rx_fifo_pkg::fifo_mode_e            fifoMode,
    input  wire logic                               laneAligned,
    input  wire logic                               sinkReady,
    output logic [rx_fifo_pkg::DATA_W-1:0]          userData,
    output logic [rx_fifo_pkg::CTRL_W-1:0]          userKind,
    output logic                                    userValid,
    rx_fifo_if.fabric                               link
);
    import rx_fifo_pkg::*;
    ctl_state_e  state;
    ctl_state_e  next_state;
    logic        next_readEnable;
    logic        next_writeEnable;
    logic        flagsUsed;

    // Flags only carry meaning in basic and Interlaken modes
    always_comb begin
        flagsUsed        = (fifoMode != MODE_TENG);
        next_state       = state;
        next_readEnable  = 1'b0;
        next_writeEnable = 1'b1;
        unique case (state)
            CTL_IDLE: begin
                // Interlaken waits for deskew before draining
                if (fifoMode != MODE_ILKN || laneAligned) begin
                    next_state = CTL_HOLD;
                end
            end
            CTL_HOLD: begin
                // Let the FIFO fill past partially-empty before reading
                if (!flagsUsed || !link.fifoPartEmpty) begin
                    next_state = CTL_RUN;
                end
            end
            CTL_RUN: begin
                next_readEnable = sinkReady && !(flagsUsed && link.fifoPartEmpty);
                if (flagsUsed && link.fifoEmpty) begin
                    next_state = CTL_HOLD;
                end
                if (fifoMode == MODE_ILKN && !laneAligned) begin
                    next_state = CTL_IDLE;
                end
            end
            default: next_state = CTL_IDLE;
        endcase
        // Throttle writes near full to prevent overflow
        if (flagsUsed && link.fifoPartFull) begin
            next_writeEnable = 1'b0;
        end
    end

    // Control registers and data capture
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state            <= CTL_IDLE;
            link.readEnable  <= 1'b0;
            link.writeEnable <= 1'b0;
            userData         <= '0;
            userKind         <= KIND_DATA;
            userValid        <= 1'b0;
        end else begin
            state            <= next_state;
            link.readEnable  <= next_readEnable;
            link.writeEnable <= next_writeEnable;
            userData         <= link.readData;
            userKind         <= link.readKind;
            userValid        <= link.readValid;
        end
    end
endmodule

//--- rx_fifo_properties.sv
// Checker of flag and handshake relations on the FIFO link
`timescale 1ns/1ps
module rx_fifo_properties
    import rx_fifo_pkg::*;
(
    input wire logic                              ref_clk,
    input wire logic                              rst,
    input wire rx_fifo_pkg::fifo_mode_e           fifoMode,
    input wire logic [rx_fifo_pkg::THRESH_W-1:0]  partFullThresh,
    input wire logic [rx_fifo_pkg::THRESH_W-1:0]  partEmptyThresh,
    input wire logic                              readValid,
    input wire logic                              readEnable,
    input wire logic                              writeEnable,
    input wire logic                              fifoFull,
    input wire logic                              fifoEmpty,
    input wire logic                              fifoPartFull,
    input wire logic                              fifoPartEmpty
);
    // Single domain, so one clocking and one reset guard
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Reset state must hold even while reset is high
    reset_state_a: assert property (disable iff (1'b0) rst |-> fifoEmpty && fifoPartEmpty
        && !fifoFull && !fifoPartFull && !readValid) else $error("flags wrong in reset");
    reset_enables_a: assert property (disable iff (1'b0) rst |-> !readEnable && !writeEnable)
        else $error("enables active in reset");
    full_not_empty_a: assert property (!(fifoFull && fifoEmpty)) else $error("full and empty");
    // Outside rate compensation a word only follows a read request
    read_cause_a: assert property (fifoMode != MODE_TENG && readValid |-> $past(readEnable))
        else $error("word without read");
    empty_pempty_a: assert property (fifoEmpty |-> fifoPartEmpty) else $error("pempty low when empty");
    full_pfull_a: assert property (fifoFull && partFullThresh <= 6'h10 |-> fifoPartFull)
        else $error("pfull low when full");
    full_pempty_a: assert property (fifoFull && partEmptyThresh < 6'h10 |-> !fifoPartEmpty)
        else $error("pempty high when full");
    // Zero threshold is always reached once reset has settled
    pfull_zero_a: assert property (!$past(rst) && partFullThresh == 6'h00 |-> fifoPartFull)
        else $error("pfull low at zero threshold");
    pempty_high_a: assert property (!$past(rst) && partEmptyThresh[5:4] == 2'b01 |-> fifoPartEmpty)
        else $error("pempty low at high threshold");

    cover property (fifoFull);
    cover property (readValid && fifoMode == MODE_ILKN);
    cover property (readValid && fifoMode == MODE_TENG);
endmodule

//--- rx_core_elastic_fifo_tb.sv
// Self-checking bench joining the FIFO device end to the fabric end
`timescale 1ns/1ps
module rx_core_elastic_fifo_tb;
    import rx_fifo_pkg::*;
    logic                ref_clk = 1'b0;
    logic                rst = 1'b0; // Rises at time zero so the async reset edge is seen
    fifo_mode_e          fifoMode = MODE_REG_BASIC;
    logic [THRESH_W-1:0] partFullThresh = PFULL_DEF;
    logic [THRESH_W-1:0] partEmptyThresh = PEMPTY_DEF;
    logic                syncDropEn = 1'b1;
    logic                ctrlDropEn = 1'b1;
    logic                blockLock = 1'b0;
    logic                frameLock = 1'b0;
    logic                laneAligned = 1'b1;
    logic                sinkReady = 1'b1;
    logic [DATA_W-1:0]   rxData = '0;
    logic [CTRL_W-1:0]   rxKind = KIND_DATA;
    logic                kindCycle = 1'b0;
    logic [31:0]         seq = 32'h1;
    logic [DATA_W-1:0]   lastData = '0;
    logic                wordDeleted;
    logic                userValid;
    logic [DATA_W-1:0]   userData;
    logic [CTRL_W-1:0]   userKind;
    int                  bad_count = 0;
    int                  checks = 0;
    int                  wordsSeen = 0;
    int                  syncSeen = 0;
    int                  ctrlSeen = 0;
    int                  delSeen = 0;
    int                  idleSeen = 0;

    rx_fifo_if link();
    rx_core_fifo #(.DEPTH(16)) rx_core_fifo_i (.ref_clk(ref_clk), .rst(rst), .fifoMode(fifoMode),
        .partFullThresh(partFullThresh), .partEmptyThresh(partEmptyThresh), .syncDropEn(syncDropEn),
        .ctrlDropEn(ctrlDropEn), .blockLock(blockLock), .frameLock(frameLock), .rxData(rxData),
        .rxKind(rxKind), .wordDeleted(wordDeleted), .link(link));
    rx_fabric_ctl rx_fabric_ctl_i (.ref_clk(ref_clk), .rst(rst), .fifoMode(fifoMode),
        .laneAligned(laneAligned), .sinkReady(sinkReady), .userData(userData), .userKind(userKind),
        .userValid(userValid), .link(link));
    rx_fifo_properties rx_fifo_properties_i (.ref_clk(ref_clk), .rst(rst), .fifoMode(fifoMode),
        .partFullThresh(partFullThresh), .partEmptyThresh(partEmptyThresh), .readValid(link.readValid),
        .readEnable(link.readEnable), .writeEnable(link.writeEnable), .fifoFull(link.fifoFull),
        .fifoEmpty(link.fifoEmpty), .fifoPartFull(link.fifoPartFull), .fifoPartEmpty(link.fifoPartEmpty));

    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d of %0d comparisons", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Rising sequence numbers, kind in the low bits so a swap shows up
    always @(posedge ref_clk) begin
        seq <= seq + 32'h1;
        rxData <= {32'h0, seq};
        rxKind <= kindCycle ? seq[1:0] : KIND_DATA;
    end

    // Inserted idles have nonzero upper bits and are checked apart; gaps are lost words
    always @(posedge ref_clk) begin
        if (wordDeleted) delSeen++;
        if (userValid && userData[63:32] == 32'h0) begin
            wordsSeen++;
            check("order", userData > lastData, 1'b1);
            check("kind", userKind, kindCycle ? userData[1:0] : KIND_DATA);
            syncSeen += (userKind == KIND_SYNC);
            ctrlSeen += (userKind == KIND_CTRL);
            lastData = userData;
        end else if (userValid) begin
            idleSeen++;
            check("idle", userData, IDLE_WORD);
            check("idlekind", userKind, KIND_OS);
        end
    end

    // Config only changes under reset, so no stale words straddle it
    task automatic restart(input fifo_mode_e m, input logic [5:0] pf, input logic [5:0] pe, input logic kc);
        rst <= 1'b1;
        fifoMode <= m;
        partFullThresh <= pf;
        partEmptyThresh <= pe;
        kindCycle <= kc;
        blockLock <= 1'b0;
        frameLock <= 1'b0;
        repeat (16) @(posedge ref_clk);
        lastData = '0;
        wordsSeen = 0;
        syncSeen = 0;
        ctrlSeen = 0;
        delSeen = 0;
        idleSeen = 0;
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic basic_fill();
        int n;
        // Threshold at the depth, so write throttling cannot stop the fill short of full
        restart(MODE_REG_BASIC, 6'h10, PEMPTY_DEF, 1'b1);
        check("empty", link.fifoEmpty, 1'b1);
        check("pempty", link.fifoPartEmpty, 1'b1);
        sinkReady <= 1'b0;
        n = 0;
        while (link.fifoFull !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        check("full", link.fifoFull, 1'b1);
        check("pfull", link.fifoPartFull, 1'b1);
        sinkReady <= 1'b1;
        repeat (100) @(posedge ref_clk);
        check("flow", wordsSeen > 20, 1'b1);
    endtask

    task automatic ilkn_drop();
        // Default thresholds, so the fabric both writes and drains
        restart(MODE_ILKN, PFULL_DEF, PEMPTY_DEF, 1'b1);
        repeat (60) @(posedge ref_clk);
        check("syncbefore", syncSeen > 0, 1'b1);
        check("ctrlbefore", ctrlSeen > 0, 1'b1);
        frameLock <= 1'b1;
        repeat (40) @(posedge ref_clk);
        syncSeen = 0;
        ctrlSeen = 0;
        wordsSeen = 0;
        repeat (100) @(posedge ref_clk);
        check("sync", syncSeen, 0);
        check("ctrl", ctrlSeen, 0);
        check("data", wordsSeen > 0, 1'b1);
    endtask

    task automatic teng_lock();
        restart(MODE_TENG, PFULL_DEF, PEMPTY_DEF, 1'b0);
        repeat (60) @(posedge ref_clk);
        check("prelock", wordsSeen, 0);
        blockLock <= 1'b1;
        repeat (100) @(posedge ref_clk);
        check("postlock", wordsSeen > 0, 1'b1);
        check("nodelete", delSeen, 0);
        check("idles", idleSeen > 0, 1'b1);
    endtask

    // Threshold extremes: zero, and beyond the depth where the partially-full flag is never reached
    task automatic thresh_range();
        restart(MODE_REG_BASIC, 6'h00, 6'h10, 1'b0);
        repeat (20) @(posedge ref_clk);
        check("pfullzero", link.fifoPartFull, 1'b1);
        check("pemptysixteen", link.fifoPartEmpty, 1'b1);
        restart(MODE_REG_BASIC, 6'h20, 6'h20, 1'b0);
        repeat (60) @(posedge ref_clk);
        check("fullhigh", link.fifoFull, 1'b1);
        check("pfullhigh", link.fifoPartFull, 1'b0);
        check("pemptyhigh", link.fifoPartEmpty, 1'b1);
    endtask

    // Main sequence
    initial begin
        basic_fill();
        ilkn_drop();
        teng_lock();
        thresh_range();
        stop_test();
    end

    // Watchdog well beyond the roughly 650 cycles the scenarios need
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        stop_test();
    end
endmodule
